// File: design/scd_strap_decoder.v
// Strap capture and decode for bridge configuration
`include "scd_map.vh"
`default_nettype none
// Notes on behaviour
// - Address bits 4:0 copy address straps
// - Clock strap low 133MHz, high 100MHz
// - Slot strap codes zero to four slots
// - Slot codes above four are invalid
// - Option bit 0 marks latch sensor
// - Option bit 1 marks attention button
// - EEPROM strap high enables load
// - Aux detect high means aux present
module scd_strap_decoder #(
  parameter SETTLE = `SCD_SETTLE_CYC
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // Straps and detect inputs
  input  wire [4:0] smbus_addr_strap,
  input  wire       port_a_clock_limit,
  input  wire       port_b_clock_limit,
  input  wire [2:0] port_a_slot_count,
  input  wire [2:0] port_b_slot_count,
  input  wire [1:0] port_a_hotplug_options,
  input  wire [1:0] port_b_hotplug_options,
  input  wire       eeprom_load_enable,
  input  wire       auxPowerDetect,
  // Decoded configuration
  output reg  [4:0] smbusAddr,
  output reg        portAMax100,
  output reg        portBMax100,
  output reg  [2:0] portASlots,
  output reg  [2:0] portBSlots,
  output reg        portASlotsBad,
  output reg        portBSlotsBad,
  output reg        portALatchSensor,
  output reg        portAAttnButton,
  output reg        portBLatchSensor,
  output reg        portBAttnButton,
  output reg        eepromLoadEn,
  output reg        auxPresent,
  output reg        configValid
);
  // Capture sequencer states
  localparam ST_SETTLE = 1'b0;
  localparam ST_HOLD   = 1'b1;
  // Packed strap bus width; field order lives in the map header
  localparam SW        = `SCD_STRAP_W;

  // Raw and filtered strap buses
  wire [SW-1:0]          strapRaw;
  wire [SW-1:0]          strapSync;
  wire                   auxSync;
  // Filtered strap fields
  wire [`SCD_ADDR_W-1:0] syncAddr;
  wire                   syncClkA;
  wire                   syncClkB;
  wire [`SCD_SLOT_W-1:0] syncSlotA;
  wire [`SCD_SLOT_W-1:0] syncSlotB;
  wire [`SCD_OPT_W-1:0]  syncOptA;
  wire [`SCD_OPT_W-1:0]  syncOptB;
  wire                   syncEeprom;
  // Capture sequencer
  reg                    stateReg;
  reg                    stateNext;
  reg  [3:0]             waitReg;
  reg  [3:0]             waitNext;
  reg                    captureNow;
  // Decoded values, loaded into the outputs on the capture edge
  reg  [`SCD_ADDR_W-1:0] addrNext;
  reg                    max100ANext;
  reg                    max100BNext;
  reg  [`SCD_SLOT_W-1:0] slotsANext;
  reg  [`SCD_SLOT_W-1:0] slotsBNext;
  reg                    badANext;
  reg                    badBNext;
  reg                    latchANext;
  reg                    buttonANext;
  reg                    latchBNext;
  reg                    buttonBNext;
  reg                    eepromNext;

  // Slot codes past four are reserved; the board must never strap them
  function slotBad;
    input [2:0] code;
    begin
      slotBad = (code > `SCD_SLOTS_MAX);
    end
  endfunction

  // Reserved codes give zero slots so no slot wakes on a bad strap
  function [2:0] slotNum;
    input [2:0] code;
    begin
      slotNum = slotBad(code) ? `SCD_SLOTS_NONE : code;
    end
  endfunction

  // Option bit for the retention latch sensor
  function latchBit;
    input [1:0] opts;
    begin
      latchBit = opts[`SCD_OPT_LATCH];
    end
  endfunction

  // Option bit for the attention button
  function buttonBit;
    input [1:0] opts;
    begin
      buttonBit = opts[`SCD_OPT_BUTTON];
    end
  endfunction

  // Pack order must match the position macros, top field first
  assign strapRaw = {smbus_addr_strap, port_a_clock_limit,
    port_b_clock_limit, port_a_slot_count, port_b_slot_count,
    port_a_hotplug_options, port_b_hotplug_options, eeprom_load_enable};

  // One filter for all straps so they settle as a set
  scd_sync #(.W(SW)) u_strap_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .rawIn    (strapRaw),
    .cleanOut (strapSync)
  );

  // Aux detect is a live level, filtered the same way
  scd_sync #(.W(1)) u_aux_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .rawIn    (auxPowerDetect),
    .cleanOut (auxSync)
  );

  // Split the filtered bus back into fields
  assign syncAddr   = strapSync[`SCD_POS_ADDR +: `SCD_ADDR_W];
  assign syncClkA   = strapSync[`SCD_POS_CLK_A];
  assign syncClkB   = strapSync[`SCD_POS_CLK_B];
  assign syncSlotA  = strapSync[`SCD_POS_SLOT_A +: `SCD_SLOT_W];
  assign syncSlotB  = strapSync[`SCD_POS_SLOT_B +: `SCD_SLOT_W];
  assign syncOptA   = strapSync[`SCD_POS_OPT_A +: `SCD_OPT_W];
  assign syncOptB   = strapSync[`SCD_POS_OPT_B +: `SCD_OPT_W];
  assign syncEeprom = strapSync[`SCD_POS_EEPROM];

  // Settle counter covers synchroniser fill before the one capture
  always @* begin
    stateNext  = stateReg;
    waitNext   = waitReg;
    captureNow = 1'b0;
    case (stateReg)
      ST_SETTLE: begin
        waitNext = waitReg + 4'h1;
        if (waitReg == SETTLE[3:0]) begin
          stateNext  = ST_HOLD;
          captureNow = 1'b1;
        end
      end
      ST_HOLD: begin
        waitNext = waitReg; // Held until next reset
      end
      default: begin
        stateNext = ST_SETTLE;
      end
    endcase
  end

  // Decode the filtered straps; only the capture edge loads them
  always @* begin
    addrNext    = syncAddr;
    max100ANext = (syncClkA == `SCD_CLK_100);
    max100BNext = (syncClkB == `SCD_CLK_100);
    slotsANext  = slotNum(syncSlotA);
    slotsBNext  = slotNum(syncSlotB);
    badANext    = slotBad(syncSlotA);
    badBNext    = slotBad(syncSlotB);
    latchANext  = latchBit(syncOptA);
    buttonANext = buttonBit(syncOptA);
    latchBNext  = latchBit(syncOptB);
    buttonBNext = buttonBit(syncOptB);
    eepromNext  = syncEeprom;
  end

  // Sequencer registers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= ST_SETTLE;
      waitReg  <= 4'h0;
    end else begin
      stateReg <= stateNext;
      waitReg  <= waitNext;
    end
  end

  // Outputs load once, then hold; later strap moves are ignored
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      smbusAddr        <= 5'h00;
      portAMax100      <= `SCD_CLK_133;
      portBMax100      <= `SCD_CLK_133;
      portASlots       <= `SCD_SLOTS_NONE;
      portBSlots       <= `SCD_SLOTS_NONE;
      portASlotsBad    <= 1'b0;
      portBSlotsBad    <= 1'b0;
      portALatchSensor <= 1'b0;
      portAAttnButton  <= 1'b0;
      portBLatchSensor <= 1'b0;
      portBAttnButton  <= 1'b0;
      eepromLoadEn     <= 1'b0;
      configValid      <= 1'b0;
    end else if (captureNow) begin
      configValid      <= 1'b1;
      smbusAddr        <= addrNext;
      portAMax100      <= max100ANext;
      portBMax100      <= max100BNext;
      portASlots       <= slotsANext;
      portBSlots       <= slotsBNext;
      portASlotsBad    <= badANext;
      portBSlotsBad    <= badBNext;
      portALatchSensor <= latchANext;
      portAAttnButton  <= buttonANext;
      portBLatchSensor <= latchBNext;
      portBAttnButton  <= buttonBNext;
      eepromLoadEn     <= eepromNext;
    end
  end

  // Aux presence is live, not a strap, so it keeps following the pin
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      auxPresent <= 1'b0;
    end else begin
      auxPresent <= auxSync;
    end
  end
endmodule // scd_strap_decoder
`default_nettype wire

// File: design/scd_map.vh
// Constants for the strap configuration decoder
`ifndef SCD_MAP_VH
`define SCD_MAP_VH
`define SCD_ADDR_W       5
`define SCD_SLOT_W       3
`define SCD_OPT_W        2
`define SCD_SLOTS_NONE   3'h0
`define SCD_SLOTS_MAX    3'h4
`define SCD_OPT_LATCH    0
`define SCD_OPT_BUTTON   1
`define SCD_CLK_133      1'h0
`define SCD_CLK_100      1'h1
`define SCD_SYNC_STAGES  3
`define SCD_SETTLE_CYC   4'h8
// Bit positions inside the packed strap bus, eeprom enable at bit 0
`define SCD_POS_EEPROM   0
`define SCD_POS_OPT_B    1
`define SCD_POS_OPT_A    3
`define SCD_POS_SLOT_B   5
`define SCD_POS_SLOT_A   8
`define SCD_POS_CLK_B    11
`define SCD_POS_CLK_A    12
`define SCD_POS_ADDR     13
`define SCD_STRAP_W      18
`endif

// File: design/scd_sync.v
// Three-stage synchroniser with agreement filter for a strap bus
`default_nettype none
module scd_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rst_n,
  // Raw and filtered data
  input  wire [W-1:0] rawIn,
  output reg  [W-1:0] cleanOut
);
  reg [W-1:0] stage1Reg;
  reg [W-1:0] stage2Reg;
  reg [W-1:0] stage3Reg;

  // Stage one feeds only stage two; output moves when two and three agree
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1Reg <= {W{1'b0}};
      stage2Reg <= {W{1'b0}};
      stage3Reg <= {W{1'b0}};
      cleanOut  <= {W{1'b0}};
    end else begin
      stage1Reg <= rawIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      if (stage2Reg == stage3Reg) begin
        cleanOut <= stage3Reg;
      end
    end
  end
endmodule // scd_sync
`default_nettype wire

// File: testbench/scd_properties.sv
// Assertions on the strap decoder ports
`default_nettype none
module scd_properties (
  // Clock, reset and capture flag
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       configValid,
  // Aux detect path
  input wire logic       auxPowerDetect,
  input wire logic       auxPresent,
  // Straps and decoded values
  input wire logic       port_a_clock_limit,
  input wire logic       portAMax100,
  input wire logic       eeprom_load_enable,
  input wire logic       eepromLoadEn,
  input wire logic       portASlotsBad,
  input wire logic       portALatchSensor,
  input wire logic       portAAttnButton,
  input wire logic [4:0] smbus_addr_strap,
  input wire logic [4:0] smbusAddr,
  input wire logic [2:0] port_a_slot_count,
  input wire logic [2:0] portASlots,
  input wire logic [1:0] port_a_hotplug_options
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Capture edge: outputs mirror straps held steady through it; reserved slot codes read as zero slots
  addr_capture_a: assert property ($rose(configValid) |->
    smbusAddr == $past(smbus_addr_strap)) else $error("address wrong");
  clock_limit_a: assert property ($rose(configValid) |->
    portAMax100 == $past(port_a_clock_limit)) else $error("clock wrong");
  slot_decode_a: assert property ($rose(configValid) &&
    $past(port_a_slot_count) <= 3'h4 |-> !portASlotsBad &&
    portASlots == $past(port_a_slot_count)) else $error("slots wrong");
  slot_reserved_a: assert property ($rose(configValid) &&
    $past(port_a_slot_count) > 3'h4 |-> portASlotsBad &&
    portASlots == 3'h0) else $error("reserved code accepted");
  latch_opt_a: assert property ($rose(configValid) |->
    portALatchSensor == $past(port_a_hotplug_options[0]))
    else $error("latch option wrong");
  button_opt_a: assert property ($rose(configValid) |->
    portAAttnButton == $past(port_a_hotplug_options[1]))
    else $error("button option wrong");
  eeprom_gate_a: assert property ($rose(configValid) |->
    eepromLoadEn == $past(eeprom_load_enable)) else $error("eeprom wrong");
  aux_follow_a: assert property ($rose(auxPowerDetect) |->
    ##[3:6] auxPresent) else $error("aux not seen");
  // Once captured the address and port A slot count may not move until the next reset
  config_hold_a: assert property (configValid && $past(configValid) |->
    $stable(smbusAddr) && $stable(portASlots)) else $error("config moved");
  valid_delay_a: assert property ($rose(rst_n) |->
    ##8 !configValid ##1 configValid) else $error("capture late");
  cover property ($rose(configValid));
  cover property ($rose(configValid) && portASlotsBad);
  cover property ($rose(auxPresent));
endmodule // scd_properties
bind scd_strap_decoder scd_properties u_props (.sys_clk, .rst_n,
  .configValid, .auxPowerDetect, .auxPresent, .port_a_clock_limit,
  .portAMax100, .eeprom_load_enable, .eepromLoadEn, .portASlotsBad,
  .portALatchSensor, .portAAttnButton, .smbus_addr_strap, .smbusAddr,
  .port_a_slot_count, .portASlots, .port_a_hotplug_options);
`default_nettype wire

// File: testbench/strap_config_decoder_test.sv
// Self-checking bench for the strap decoder
`default_nettype none
module strap_config_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0, rst_n = 1'b0, auxPowerDetect = 1'b0;
  logic [4:0] smbus_addr_strap = 5'h00, smbusAddr;
  logic       port_a_clock_limit = 1'b0, port_b_clock_limit = 1'b0;
  logic [2:0] port_a_slot_count = 3'h0, port_b_slot_count = 3'h0;
  logic [1:0] port_a_hotplug_options = 2'h0, port_b_hotplug_options = 2'h0;
  logic       eeprom_load_enable = 1'b0, eepromLoadEn, auxPresent;
  logic [2:0] portASlots, portBSlots;
  logic       portAMax100, portBMax100, portASlotsBad, portBSlotsBad;
  logic       portALatchSensor, portAAttnButton, portBLatchSensor;
  logic       portBAttnButton, configValid;
  int         num_errors = 0, n_tests = 0;
  always #4 sys_clk = ~sys_clk;
  scd_strap_decoder u_dut (.sys_clk, .rst_n, .smbus_addr_strap,
    .port_a_clock_limit, .port_b_clock_limit, .port_a_slot_count,
    .port_b_slot_count, .port_a_hotplug_options, .port_b_hotplug_options,
    .eeprom_load_enable, .auxPowerDetect, .smbusAddr, .portAMax100,
    .portBMax100, .portASlots, .portBSlots, .portASlotsBad, .portBSlotsBad,
    .portALatchSensor, .portAAttnButton, .portBLatchSensor,
    .portBAttnButton, .eepromLoadEn, .auxPresent, .configValid);
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Reserved codes must read as no slots
  function automatic logic [2:0] sl(logic [2:0] v);
    return (v > 3'h4) ? 3'h0 : v;
  endfunction
  // Strap one pattern through reset; bounded wait for capture
  task automatic boot(logic [2:0] c);
    int k;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    {smbus_addr_strap, port_a_clock_limit, port_b_clock_limit} <=
      {c[1:0], c, c[0], c[1]};
    {port_a_slot_count, port_b_slot_count} <= {c, c[0], c[2:1]};
    {port_a_hotplug_options, port_b_hotplug_options} <=
      {c[1:0], c[2:1]};
    eeprom_load_enable <= c[2];
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (k = 0; k < 20 && configValid !== 1'b1; k++) @(posedge sys_clk) #1;
    if (k == 20) begin
      chk("configValid", 8'h01, {7'h00, configValid});
      give_verdict();
    end
  endtask
  // Every slot code once; code zero is the open-strap default
  initial begin
    for (int c = 0; c < 8; c++) begin
      logic [2:0] v, w;
      v = c[2:0];
      w = {v[0], v[2:1]};
      boot(v);
      chk("smbusAddr", {v[1:0], v}, smbusAddr);
      chk("max100", {v[0], v[1]}, {portAMax100, portBMax100});
      chk("slots", {sl(v), sl(w)}, {portASlots, portBSlots});
      chk("slotsBad", {v > 3'h4, w > 3'h4}, {portASlotsBad,
        portBSlotsBad});
      chk("options", {v[1:0], v[2:1]}, {portAAttnButton,
        portALatchSensor, portBAttnButton, portBLatchSensor});
      chk("eepromLoadEn", v[2], eepromLoadEn);
      @(posedge sys_clk);
      smbus_addr_strap <= ~smbus_addr_strap;
      port_a_slot_count <= ~v;
      repeat (12) @(posedge sys_clk) #1;
      chk("held", {v[1:0], v, sl(v)}, {smbusAddr, portASlots});
    end
    @(posedge sys_clk);
    auxPowerDetect <= 1'b1;
    repeat (7) @(posedge sys_clk) #1;
    chk("auxPresent", 8'h01, auxPresent);
    @(posedge sys_clk);
    auxPowerDetect <= 1'b0;
    repeat (7) @(posedge sys_clk) #1;
    chk("auxAbsent", 8'h00, auxPresent);
    give_verdict();
  end
endmodule // strap_config_decoder_test
`default_nettype wire
